// *** hw/pid_setpoint_speed_control.sv ***
// The register addresses and register access over Wishbone were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module pid_setpoint_speed_control
  import pid_pkg::*;
#(
  parameter int SAMPLE_CYCLES_P = SAMPLE_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire wb_req_s wb_req_i,
  output var wb_rsp_s wb_rsp_o,
  input wire logic [11:0] volt_in_i,
  input wire logic [11:0] curr_in_i,
  input wire logic fault_i,
  input wire fault_s fault_data_i,
  input wire logic lang_mem_present_i,
  output logic [15:0] speed_cmd_o,
  output var src_e source_o,
  output logic loop_closed_o,
  output logic low_alarm_o,
  output logic high_alarm_o,
  output logic start_relay_o
);

  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] dat,
                                          input logic [3:0] sel);
    merge16 = {sel[1] ? dat[15:8] : old[15:8],
               sel[0] ? dat[7:0] : old[7:0]};
  endfunction

  function automatic logic [15:0] scale16(input logic [11:0] code,
                                          input logic [15:0] lo,
                                          input logic [15:0] hi);
    logic signed [31:0] span;
    logic signed [31:0] v;
    span = $signed({16'h0, hi}) - $signed({16'h0, lo});
    v = $signed({16'h0, lo}) + span * $signed({20'h0, code})
        / $signed({20'h0, CODE_FULL});
    scale16 = v[15:0];
  endfunction

  function automatic logic [15:0] clamp_pct(input logic signed [47:0] v);
    if (v < 0) begin
      clamp_pct = 16'h0000;
    end else if (v > $signed({32'h0, PCT_FULL})) begin
      clamp_pct = PCT_FULL;
    end else begin
      clamp_pct = v[15:0];
    end
  endfunction

  function automatic logic [15:0] cfg_dflt(input logic [3:0] idx);
    case (idx)
      IDX_FB_HIGH: cfg_dflt = DFLT_FB_HIGH;
      IDX_P_GAIN: cfg_dflt = DFLT_P_GAIN;
      IDX_ALM_HIGH: cfg_dflt = DFLT_ALM_HIGH;
      default: cfg_dflt = 16'h0000;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////

  wb_rsp_s rsp_q;
  logic [15:0] cfg_q [NUM_CFG];
  logic [15:0] cfg_d [NUM_CFG];
  logic [15:0] cfg_rd;
  fault_s log_q [NUM_LOG];
  fault_s log_d [NUM_LOG];
  mode_e mode_q;
  src_e src;
  src_e src_q;
  logic [15:0] speed_q;
  logic [15:0] cmd_d;
  logic [15:0] sp_ramp_q;
  logic signed [47:0] integ_q;
  logic signed [47:0] err_prev_q;
  logic [31:0] tick_cnt_q;
  logic tick_q;
  logic loop_closed_q;
  logic low_q;
  logic high_q;
  logic start_q;

  // A request is taken once; ack is registered and drops the cycle after.
  wire logic req = wb_req_i.cyc & wb_req_i.stb & ~rsp_q.ack;
  wire logic wr = req & wb_req_i.we;
  wire logic [3:0] ridx = wb_req_i.adr[5:2];
  wire logic [2:0] lidx = wb_req_i.adr[4:2];
  wire logic page0 = wb_req_i.adr[7:6] == ADR_CFG_PAGE;
  wire logic log_hit = wb_req_i.adr[7:5] == ADR_LOG_PAGE;

  wire logic [15:0] ctrl = cfg_q[IDX_CTRL];
  wire logic [1:0] loop_mode = ctrl[CTRL_MODE_LSB +: 2];
  wire logic fb_sel = ctrl[CTRL_FB_SEL];
  wire logic auto_mode = ctrl[CTRL_AUTO];
  wire logic remote = ctrl[CTRL_REMOTE];
  wire logic [1:0] sp_sel = ctrl[CTRL_SP_LSB +: 2];
  wire logic clr_act = ctrl[CTRL_LOG_CLEAR];
  wire logic restore_act = ctrl[CTRL_RESTORE];
  wire logic [15:0] key_speed = cfg_q[IDX_KEY_SPEED];
  wire logic [15:0] key_sp = cfg_q[IDX_KEY_SP];
  wire logic [15:0] fb_lo = cfg_q[IDX_FB_LOW];
  wire logic [15:0] fb_hi = cfg_q[IDX_FB_HIGH];
  wire logic [15:0] ramp_t = cfg_q[IDX_RAMP];
  wire logic [15:0] alm_lo = cfg_q[IDX_ALM_LOW];
  wire logic [15:0] alm_hi = cfg_q[IDX_ALM_HIGH];

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers. Clear and restore are written as one and the
  // hardware drops them back to zero after acting for one cycle.

  for (genvar g = 0; g < NUM_CFG; g++) begin : g_cfg
    wire logic hit = wr & page0 & (ridx == 4'(g));
    wire logic [15:0] wval = merge16(cfg_q[g], wb_req_i.dat, wb_req_i.sel);
    if (g == int'(IDX_CTRL)) begin : g_ctrl
      assign cfg_d[g] = restore_act ?
        ((cfg_dflt(4'(g)) & ~LANG_MASK) | (cfg_q[g] & LANG_MASK)) :
        hit ? wval : (cfg_q[g] & ~SELF_CLR_MASK);
    end else begin : g_data
      assign cfg_d[g] = restore_act ? cfg_dflt(4'(g)) :
                        hit ? wval : cfg_q[g];
    end
  end

  always_ff @(posedge clk_i) begin
    for (int i = 0; i < NUM_CFG; i++) begin
      cfg_q[i] <= rst_i ? cfg_dflt(4'(i)) : cfg_d[i];
    end
  end

  always_comb begin
    cfg_rd = 16'h0000;
    for (int i = 0; i < NUM_CFG; i++) begin
      if (ridx == 4'(i)) begin
        cfg_rd = cfg_q[i];
      end
    end
  end

  // Without the language memory the selection always reads as English.
  wire logic [3:0] lang_eff = lang_mem_present_i ?
                              ctrl[CTRL_LANG_LSB +: 4] : LANG_ENGLISH;
  wire logic [15:0] ctrl_rd =
    (ctrl & ~LANG_MASK) | ({12'h000, lang_eff} << CTRL_LANG_LSB);
  wire logic [15:0] stat_rd = {5'h00, mode_q, 2'h0, src_q, loop_closed_q,
                               start_q, high_q, low_q};
  wire fault_s log_rd = log_q[lidx];
  wire logic [31:0] log_word = {12'h000, {1'b0, lidx} + 4'h1, 4'h0,
                                log_rd.state, log_rd.code};

  logic [15:0] page0_rd;
  wire logic [15:0] fb_scaled;
  always_comb begin
    page0_rd = 16'h0000;
    if (ridx == IDX_CTRL) begin
      page0_rd = ctrl_rd;
    end else if (ridx <= IDX_ALM_HIGH) begin
      page0_rd = cfg_rd;
    end else if (ridx == IDX_STATUS) begin
      page0_rd = stat_rd;
    end else if (ridx == IDX_SPEED) begin
      page0_rd = speed_q;
    end else if (ridx == IDX_FEEDBACK) begin
      page0_rd = fb_scaled;
    end
  end

  wire logic [31:0] rd_data = page0 ? {16'h0000, page0_rd} :
                              log_hit ? log_word : 32'h0000_0000;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rsp_q <= '0;
    end else begin
      rsp_q.ack <= req;
      if (req) begin
        rsp_q.dat <= rd_data;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sample tick: every loop and ramp update happens on this pulse.

  wire logic tick_end = tick_cnt_q == 32'(SAMPLE_CYCLES_P - 1);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tick_cnt_q <= 32'h0;
      tick_q <= 1'b0;
    end else begin
      tick_cnt_q <= tick_end ? 32'h0 : tick_cnt_q + 32'h1;
      tick_q <= tick_end;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Loop mode and reference source.

  wire logic loop_on = (loop_mode == LOOP_DIRECT) |
                       (loop_mode == LOOP_REVERSE);
  wire logic reverse = loop_mode == LOOP_REVERSE;
  wire mode_e mode_d = !loop_on ? MODE_OPEN :
                       auto_mode ? MODE_CLOSED : MODE_MANUAL;

  always_comb begin
    case (mode_q)
      MODE_CLOSED: begin
        if (remote && sp_sel == SP_VOLTAGE) begin
          src = SRC_VOLTAGE;
        end else if (remote && sp_sel == SP_CURRENT) begin
          src = SRC_CURRENT;
        end else begin
          src = SRC_AUTO_KEYPAD;
        end
      end
      MODE_MANUAL: src = SRC_MANUAL_KEYPAD;
      MODE_OPEN: begin
        if (auto_mode) begin
          src = fb_sel ? SRC_CURRENT : SRC_VOLTAGE;
        end else begin
          src = SRC_MANUAL_KEYPAD;
        end
      end
      default: src = SRC_MANUAL_KEYPAD;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Feedback scaling, setpoint ramp and the three loop terms.

  wire logic [11:0] fb_code = fb_sel ? curr_in_i : volt_in_i;
  assign fb_scaled = scale16(fb_code, fb_lo, fb_hi);
  wire logic [15:0] sp_target =
    (src == SRC_VOLTAGE) ? scale16(volt_in_i, fb_lo, fb_hi) :
    (src == SRC_CURRENT) ? scale16(curr_in_i, fb_lo, fb_hi) : key_sp;

  wire logic [15:0] fb_full = (fb_lo > fb_hi) ? fb_lo : fb_hi;
  wire logic [15:0] norm = (fb_full == 16'h0) ? 16'h0001 : fb_full;

  // The step is full scale divided by the ramp time in ticks, truncated, but at least 1.
  wire logic [31:0] ramp_ticks = 32'(ramp_t) * 32'(RAMP_TICKS_PER_UNIT);
  wire logic [31:0] ramp_div = 32'(norm) /
                               ((ramp_ticks == 32'h0) ? 32'h1 : ramp_ticks);
  wire logic [15:0] ramp_step = (ramp_div == 32'h0) ? 16'h0001 :
                                ramp_div[15:0];
  wire logic sp_up = sp_target > sp_ramp_q;
  wire logic [15:0] sp_gap = sp_up ? sp_target - sp_ramp_q :
                                     sp_ramp_q - sp_target;
  wire logic sp_jump = (ramp_t == 16'h0) | (mode_q != MODE_CLOSED) |
                       (sp_gap <= ramp_step);
  wire logic [15:0] sp_next = sp_jump ? sp_target :
                              sp_up ? sp_ramp_q + ramp_step :
                                      sp_ramp_q - ramp_step;

  localparam logic signed [47:0] PCT_S = $signed({32'h0, PCT_FULL});
  wire logic signed [47:0] err_raw =
    $signed({32'h0, sp_ramp_q}) - $signed({32'h0, fb_scaled});
  wire logic signed [47:0] err_dir = reverse ? -err_raw : err_raw;
  wire logic signed [47:0] err_pct = err_dir * PCT_S /
                                     $signed({32'h0, norm});
  // Limiting the error to one full scale keeps every product in 48 bits.
  wire logic signed [47:0] err_lim = (err_pct > PCT_S) ? PCT_S :
                                     (err_pct < -PCT_S) ? -PCT_S : err_pct;

  wire logic signed [47:0] p_term =
    (err_lim * $signed({32'h0, cfg_q[IDX_P_GAIN]})) >>> Q_FRAC;
  wire logic signed [47:0] integ_sum =
    integ_q + err_lim * $signed({32'h0, cfg_q[IDX_I_GAIN]});
  wire logic signed [47:0] integ_d = (integ_sum > I_LIMIT) ? I_LIMIT :
    (integ_sum < -I_LIMIT) ? -I_LIMIT : integ_sum;
  wire logic signed [47:0] i_term = integ_q / I_SCALE;
  wire logic signed [47:0] d_term = ((err_lim - err_prev_q) *
    $signed({32'h0, cfg_q[IDX_D_GAIN]}) * 48'(TICKS_PER_S)) >>> Q_FRAC;
  wire logic [15:0] loop_cmd = clamp_pct(p_term + i_term + d_term);
  wire logic [31:0] analog_pct =
    (32'(fb_code) * 32'(PCT_FULL)) / 32'(CODE_FULL);

  always_comb begin
    case (mode_q)
      MODE_CLOSED: cmd_d = loop_cmd;
      MODE_MANUAL: cmd_d = clamp_pct($signed({32'h0, key_speed}));
      MODE_OPEN: begin
        cmd_d = auto_mode ? analog_pct[15:0] :
                clamp_pct($signed({32'h0, key_speed}));
      end
      default: cmd_d = 16'h0000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_q <= MODE_OPEN;
      src_q <= SRC_MANUAL_KEYPAD;
      loop_closed_q <= 1'b0;
      speed_q <= 16'h0000;
      sp_ramp_q <= 16'h0000;
      err_prev_q <= '0;
    end else begin
      mode_q <= mode_d;
      src_q <= src;
      loop_closed_q <= mode_q == MODE_CLOSED;
      if (tick_q) begin
        speed_q <= cmd_d;
        sp_ramp_q <= sp_next;
        err_prev_q <= err_lim;
      end
    end
  end

  // The integrator is held at zero outside closed loop to avoid windup.
  always_ff @(posedge clk_i) begin
    if (rst_i || mode_q != MODE_CLOSED) begin
      integ_q <= '0;
    end else if (tick_q) begin
      integ_q <= integ_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Alarms. The selected analog input is watched in every mode.

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      low_q <= 1'b0;
      high_q <= 1'b0;
      start_q <= 1'b0;
    end else begin
      low_q <= fb_scaled < alm_lo;
      high_q <= fb_scaled > alm_hi;
      start_q <= remote & (fb_scaled >= alm_lo);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Trip log, entry 0 newest. A fault in the clearing cycle is kept.

  for (genvar g = 0; g < NUM_LOG; g++) begin : g_log
    if (g == 0) begin : g_head
      assign log_d[g] = fault_i ? fault_data_i :
                        clr_act ? NO_FAULT_ENTRY : log_q[g];
    end else begin : g_tail
      assign log_d[g] = clr_act ? NO_FAULT_ENTRY :
                        fault_i ? log_q[g - 1] : log_q[g];
    end
  end

  always_ff @(posedge clk_i) begin
    for (int i = 0; i < NUM_LOG; i++) begin
      log_q[i] <= rst_i ? NO_FAULT_ENTRY : log_d[i];
    end
  end

  assign wb_rsp_o = rsp_q;
  assign speed_cmd_o = speed_q;
  assign source_o = src_q;
  assign loop_closed_o = loop_closed_q;
  assign low_alarm_o = low_q;
  assign high_alarm_o = high_q;
  assign start_relay_o = start_q;

  ////////////////////////////////////////////////////////////////////////////

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  open_no_integ_a: assert property (
    mode_q == MODE_OPEN |=> integ_q == 48'sh0 && !loop_closed_q)
    else $error("integrator or loop active in open mode");
  direct_sign_a: assert property (
    mode_q == MODE_CLOSED && !reverse && fb_scaled > sp_ramp_q
    |-> err_lim <= 0)
    else $error("direct acting error has wrong sign");
  reverse_sign_a: assert property (
    mode_q == MODE_CLOSED && reverse && fb_scaled > sp_ramp_q
    |-> err_lim >= 0)
    else $error("reverse acting error has wrong sign");
  local_src_a: assert property (
    mode_q == MODE_CLOSED && !remote |=> src_q == SRC_AUTO_KEYPAD)
    else $error("local auto loop not on keypad");
  manual_src_a: assert property (
    mode_q == MODE_MANUAL ##1 mode_q == MODE_MANUAL
    |-> src_q == SRC_MANUAL_KEYPAD)
    else $error("manual mode not on manual keypad");
  low_alarm_a: assert property (
    fb_scaled < alm_lo |=> low_q && !start_q)
    else $error("low alarm missed");
  start_remote_a: assert property (
    !remote |=> !start_q)
    else $error("start output outside remote");
  log_shift_a: assert property (
    fault_i && !clr_act |=> log_q[1] == $past(log_q[0]) &&
    log_q[0] == $past(fault_data_i))
    else $error("trip log did not shift");
  log_clear_a: assert property (
    clr_act && !fault_i |=> log_q[0] == NO_FAULT_ENTRY &&
    log_q[7] == NO_FAULT_ENTRY && !ctrl[CTRL_LOG_CLEAR])
    else $error("trip log not cleared");
  lang_keep_a: assert property (
    restore_act |=> ctrl[CTRL_LANG_LSB +: 4] ==
    $past(ctrl[CTRL_LANG_LSB +: 4]))
    else $error("restore changed language");
  cmd_limit_a: assert property (
    speed_q <= PCT_FULL)
    else $error("speed command above full scale");
  ack_pulse_a: assert property (
    rsp_q.ack |=> !rsp_q.ack)
    else $error("ack longer than one cycle");

  closed_tick_c: cover property (mode_q == MODE_CLOSED && tick_q);
  ramp_step_c: cover property (tick_q && !sp_jump);
  fault_clear_c: cover property (fault_i && clr_act);
  remote_volt_c: cover property (src_q == SRC_VOLTAGE && loop_closed_q);

endmodule

`default_nettype wire

// *** inc/pid_pkg.sv ***
package pid_pkg;

  localparam int CLK_PERIOD_PS = 4000;
  localparam int SAMPLE_PERIOD_US = 1000;
  localparam int SAMPLE_CYCLES =
    SAMPLE_PERIOD_US * 1000000 / CLK_PERIOD_PS;
  localparam int TICKS_PER_S = 1000000 / SAMPLE_PERIOD_US;
  // Ramp time is programmed in tenths of a second.
  localparam int RAMP_UNITS_PER_S = 10;
  localparam int RAMP_TICKS_PER_UNIT = TICKS_PER_S / RAMP_UNITS_PER_S;

  // Percent values are Q8.8: 100 % of maximum speed is 0x6400.
  localparam logic [15:0] PCT_FULL = 16'h6400;
  localparam int Q_FRAC = 8;
  localparam logic [11:0] CODE_FULL = 12'hfff;
  localparam logic signed [47:0] I_SCALE = 48'(256 * TICKS_PER_S);
  localparam logic signed [47:0] I_LIMIT = 48'(PCT_FULL) * I_SCALE;

  localparam int NUM_CFG = 11;
  localparam int NUM_LOG = 8;

  localparam logic [1:0] ADR_CFG_PAGE = 2'h0;
  localparam logic [2:0] ADR_LOG_PAGE = 3'h2;
  localparam logic [3:0] IDX_CTRL = 4'h0;
  localparam logic [3:0] IDX_KEY_SPEED = 4'h1;
  localparam logic [3:0] IDX_KEY_SP = 4'h2;
  localparam logic [3:0] IDX_FB_LOW = 4'h3;
  localparam logic [3:0] IDX_FB_HIGH = 4'h4;
  localparam logic [3:0] IDX_P_GAIN = 4'h5;
  localparam logic [3:0] IDX_I_GAIN = 4'h6;
  localparam logic [3:0] IDX_D_GAIN = 4'h7;
  localparam logic [3:0] IDX_RAMP = 4'h8;
  localparam logic [3:0] IDX_ALM_LOW = 4'h9;
  localparam logic [3:0] IDX_ALM_HIGH = 4'ha;
  localparam logic [3:0] IDX_STATUS = 4'hb;
  localparam logic [3:0] IDX_SPEED = 4'hc;
  localparam logic [3:0] IDX_FEEDBACK = 4'hd;

  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_FB_SEL = 2;
  localparam int CTRL_AUTO = 3;
  localparam int CTRL_REMOTE = 4;
  localparam int CTRL_SP_LSB = 5;
  localparam int CTRL_LANG_LSB = 8;
  localparam int CTRL_LOG_CLEAR = 12;
  localparam int CTRL_RESTORE = 13;
  localparam logic [15:0] LANG_MASK = 16'h0f00;
  localparam logic [15:0] SELF_CLR_MASK = 16'h3000;

  localparam logic [1:0] LOOP_OFF = 2'h0;
  localparam logic [1:0] LOOP_DIRECT = 2'h1;
  localparam logic [1:0] LOOP_REVERSE = 2'h2;
  localparam logic [1:0] SP_VOLTAGE = 2'h1;
  localparam logic [1:0] SP_CURRENT = 2'h2;
  localparam logic [3:0] LANG_ENGLISH = 4'h0;
  localparam logic [7:0] NO_FAULT = 8'h00;

  localparam logic [15:0] DFLT_FB_HIGH = 16'h03e8;
  localparam logic [15:0] DFLT_P_GAIN = 16'h0100;
  localparam logic [15:0] DFLT_ALM_HIGH = 16'hffff;

  typedef enum logic [2:0] {
    MODE_OPEN = 3'b001,
    MODE_MANUAL = 3'b010,
    MODE_CLOSED = 3'b100
  } mode_e;

  typedef enum logic [1:0] {
    SRC_MANUAL_KEYPAD = 2'h0,
    SRC_AUTO_KEYPAD = 2'h1,
    SRC_VOLTAGE = 2'h2,
    SRC_CURRENT = 2'h3
  } src_e;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [31:0] dat;
    logic [3:0] sel;
  } wb_req_s;

  typedef struct packed {
    logic [31:0] dat;
    logic ack;
  } wb_rsp_s;

  typedef struct packed {
    logic [7:0] code;
    logic [3:0] state;
  } fault_s;

  localparam fault_s NO_FAULT_ENTRY = '{code: NO_FAULT, state: 4'h0};

endpackage

// *** verif/analog_source_model.sv ***
`timescale 1ns/1ps
`default_nettype none

// Stands for the process transducer and the analog setpoint sources.
// A real transducer settles slowly, so new levels show one cycle late.
module analog_source_model (
  input wire logic clk_i,
  input wire logic [11:0] volt_set_i,
  input wire logic [11:0] curr_set_i,
  output logic [11:0] volt_o,
  output logic [11:0] curr_o
);
  always_ff @(posedge clk_i) begin
    volt_o <= volt_set_i;
    curr_o <= curr_set_i;
  end
endmodule

`default_nettype wire

// *** verif/pid_setpoint_speed_control_tb.sv ***
`timescale 1ns/1ps
`default_nettype none

module pid_setpoint_speed_control_tb import pid_pkg::*;;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  wb_req_s req = '0;
  wb_rsp_s rsp;
  logic [11:0] v_set = 12'h0;
  logic [11:0] c_set = 12'h0;
  logic [11:0] volt;
  logic [11:0] curr;
  logic [15:0] spd;
  src_e so;
  logic lc;
  logic alo;
  logic ahi;
  logic st;
  logic flt = 1'b0;
  fault_s fdat = '0;
  logic lang = 1'b1;
  logic [63:0] q[$];
  fault_s log_m[8];
  int fails = 0;
  int checks = 0;

  pid_setpoint_speed_control #(.SAMPLE_CYCLES_P(8)) uut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req), .wb_rsp_o(rsp),
    .volt_in_i(volt), .curr_in_i(curr), .fault_i(flt),
    .fault_data_i(fdat), .lang_mem_present_i(lang), .speed_cmd_o(spd),
    .source_o(so), .loop_closed_o(lc), .low_alarm_o(alo),
    .high_alarm_o(ahi), .start_relay_o(st)
  );

  analog_source_model src_m (
    .clk_i(clk_i), .volt_set_i(v_set), .curr_set_i(c_set),
    .volt_o(volt), .curr_o(curr)
  );

  initial begin
    forever #2 clk_i = ~clk_i;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic cmp(input logic [31:0] g, input logic [63:0] n);
    checks++;
    if ((g & n[31:0]) !== n[63:32]) begin
      fails++;
      $display("wrong value at %0t: got %h want %h", $time, g, n[63:32]);
    end
  endtask

  // Read data is judged at the ack edge, while the request still stands.
  always @(posedge clk_i) begin
    if (rsp.ack === 1'b1 && req.cyc === 1'b1 && req.we === 1'b0) begin
      cmp(rsp.dat, q.pop_front());
    end
  end

  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, input logic [31:0] e = '0,
                    input logic [31:0] m = '1);
    if (!w) q.push_back({e & m, m});
    req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, dat: d, sel: 4'h3};
    // Only the watchdog ends a wait for a missing ack.
    do begin
      @(posedge clk_i);
    end while (rsp.ack !== 1'b1);
    req <= '0;
    @(posedge clk_i);
  endtask

  task automatic faults(input int k);
    for (int i = 0; i < k; i++) begin
      fault_s f;
      f.code = 8'($urandom_range(1, 255));
      f.state = 4'($urandom);
      for (int j = 7; j > 0; j--) log_m[j] = log_m[j - 1];
      log_m[0] = f;
      fdat <= f;
      flt <= 1'b1;
      @(posedge clk_i);
    end
    flt <= 1'b0;
  endtask

  task automatic row(input logic [15:0] c, input logic [11:0] v,
                     input logic [11:0] i, input logic [15:0] s,
                     input logic [15:0] sm, input logic [15:0] t,
                     input logic [15:0] tm);
    v_set <= v;
    c_set <= i;
    wb(1, 8'h00, {16'h0, c});
    repeat (40) @(posedge clk_i);
    @(negedge clk_i);
    cmp({16'h0, spd}, {16'h0, s, 16'h0, sm});
    cmp({26'h0, so, lc, st, ahi, alo},
        {26'h0, t[5:0], 26'h0, tm[5:0]});
    @(posedge clk_i);
    wb(0, 8'h30, 0, {16'h0, s}, {16'h0, sm});
    wb(0, 8'h2c, 0, {16'h0, t}, {16'h0, tm});
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(18264));
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(0, 8'h10, 0, 32'h3e8);
    wb(0, 8'h14, 0, 32'h100);
    wb(0, 8'h28, 0, 32'hffff);
    wb(0, 8'h0c, 0, 32'h0);
    wb(0, 8'h3c, 0, 32'h0);
    $display("test 1 done");
    faults(9);
    wb(1, 8'h40, 32'hff);
    for (int k = 0; k < 8; k++) begin
      wb(0, 8'(64 + 4 * k), 0, {12'h0, 4'(k + 1), 4'h0,
         log_m[k].state, log_m[k].code});
    end
    wb(1, 8'h00, 32'h1000);
    wb(0, 8'h00, 0, 32'h0, 32'h1000);
    for (int k = 0; k < 8; k++) wb(0, 8'(64 + 4 * k), 0, 0, 32'hfff);
    $display("test 2 done");
    wb(1, 8'h00, 32'h0300);
    wb(1, 8'h14, 32'h0500);
    wb(1, 8'h00, 32'h2300);
    wb(0, 8'h00, 0, 32'h0300, 32'h2f00);
    wb(0, 8'h14, 0, 32'h0100);
    lang <= 1'b0;
    wb(0, 8'h00, 0, 32'h0, 32'h0f00);
    $display("test 3 done");
    wb(1, 8'h04, 32'h1900);
    wb(1, 8'h08, 32'h1f4);
    wb(1, 8'h24, 32'h3e8);
    wb(1, 8'h28, 32'h3e7);
    row(16'h10, 12'h0, 12'h0, 0, 0, 16'h1, 16'h7);
    row(16'h10, 12'hfff, 12'h0, 0, 0, 16'h6, 16'h7);
    row(16'h14, 12'hfff, 12'h0, 0, 0, 16'h1, 16'h7);
    row(16'h00, 12'hfff, 12'h0, 0, 0, 16'h2, 16'h7);
    row(16'h00, 12'h0, 12'h0, 16'h1900, 16'hffff, 16'h100, 16'h708);
    row(16'h08, 12'hfff, 12'h0, 16'h6400, 16'hffff, 0, 0);
    row(16'h01, 12'h0, 12'h0, 16'h1900, 16'hffff, 16'h200, 16'h738);
    row(16'h0a, 12'h0, 12'h0, 16'h0, 16'hffff, 16'h418, 16'h738);
    row(16'h0a, 12'hfff, 12'h0, 16'h3200, 16'hffff, 16'h418, 16'h738);
    row(16'h09, 12'hfff, 12'h0, 16'h0, 16'hffff, 16'h418, 16'h738);
    row(16'h09, 12'h0, 12'h0, 16'h3200, 16'hffff, 16'h418, 16'h738);
    $display("test 4 done");
    wb(1, 8'h20, 32'h14);
    wb(1, 8'h08, 32'h0);
    repeat (40) @(posedge clk_i);
    wb(0, 8'h30, 0, 32'h3100, 32'hff00);
    wb(1, 8'h20, 32'h0);
    repeat (40) @(posedge clk_i);
    wb(0, 8'h30, 0, 32'h0);
    // Half-scale error with a large integral gain must drive to full speed.
    wb(1, 8'h08, 32'h1f4);
    wb(1, 8'h18, 32'hffff);
    repeat (100) @(posedge clk_i);
    wb(0, 8'h30, 0, 32'h6400);
    wb(1, 8'h18, 32'h0);
    $display("test 5 done");
    row(16'h19, 12'h0, 12'h0, 0, 0, 16'h418, 16'h738);
    row(16'h39, 12'h0, 12'h0, 0, 0, 16'h428, 16'h738);
    row(16'h59, 12'h0, 12'h0, 0, 0, 16'h438, 16'h738);
    $display("test 6 done");
    close_out();
  end

  // Whole run is under 2000 cycles; ten times that means a hang.
  initial begin
    repeat (20000) @(posedge clk_i);
    fails++;
    close_out();
  end
endmodule

`default_nettype wire
